//--- hdl/dual_wiper_setting_store.sv
// Dual wiper control logic with two-wire slave and stored settings
// Function
// (R1) Each pot has its own 6-bit wiper position register.
// (R2) Four 6-bit stored settings retained per pot.
// (R3) At power-up each first stored setting loads into its wiper.
// (R4) Write protect low blocks stored-setting writes; wiper writes still allowed.
// (R5) Write protect high permits every read and write.
// (R6) Respond only when address matches the four select inputs.
// (R7) Each pot has 63 elements, giving 64 selectable taps.
// (R8) Exactly one tap per pot, chosen by its wiper register.
// (R9) Master can read and write wipers and stored settings.
// (R10) Instructions copy between a wiper and its own stored settings.
// (R11) Increment/decrement mode steps the wiper up or down.
// (R12) Serial data is open drain: pull low or release only.
// (R13) All transfers are clocked from the master's serial clock.
// (R14) Blocked stored writes leave data intact; bus continues normally.
`timescale 1ns/100ps
module dual_wiper_setting_store
#(
    parameter logic [pot_pkg::SEL_W-1:0] TYPE_ID = pot_pkg::DEV_TYPE_ID
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [pot_pkg::SEL_W-1:0] deviceSelect,
    input wire logic writeProtectN,
    output logic [pot_pkg::NUM_POTS-1:0][pot_pkg::WIPER_W-1:0] wiperPos,
    output logic [pot_pkg::NUM_POTS-1:0][pot_pkg::TAP_COUNT-1:0] tapSelect
);
    import pot_pkg::*;

    setting_mem_if memBus ();

    stored_setting_mem u_mem
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port(memBus.mem)
    );

    // Serial clock domain: sample the data line on every rising edge
    logic [1:0] sclRstSync_r;
    logic sclRstN;
    logic sclBit_r;
    logic sclTog_r;

    always_ff @(posedge sclClk)
    begin
        sclRstSync_r <= {sclRstSync_r[0], reset_n};
    end
    assign sclRstN = sclRstSync_r[1];

    always_ff @(posedge sclClk)
    begin
        if (!sclRstN)
        begin
            sclBit_r <= 1'b0;
            sclTog_r <= 1'b0;
        end
        else
        begin
            sclBit_r <= sdaIn; // [R13]
            sclTog_r <= ~sclTog_r; // [R13]
        end
    end

    // System domain synchronisers
    logic [2:0] togSync_r;
    logic [2:0] sclSync_r;
    logic [2:0] sdaSync_r;
    logic [1:0] wpSync_r;
    logic [SEL_W-1:0] selSync1_r;
    logic [SEL_W-1:0] selSync2_r;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            togSync_r <= 3'h0;
            sclSync_r <= 3'h7;
            sdaSync_r <= 3'h7;
            wpSync_r <= 2'h3;
            selSync1_r <= 4'h0;
            selSync2_r <= 4'h0;
        end
        else
        begin
            togSync_r <= {togSync_r[1:0], sclTog_r};
            sclSync_r <= {sclSync_r[1:0], sclClk};
            sdaSync_r <= {sdaSync_r[1:0], sdaIn};
            wpSync_r <= {wpSync_r[0], writeProtectN};
            selSync1_r <= deviceSelect;
            selSync2_r <= selSync1_r;
        end
    end

    logic bitValid;
    logic bitVal;
    logic sclHigh;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic nvAllowed;

    // The sampled bit is held for a whole serial clock period, long
    // after its toggle has crossed, so reading it here is stable
    assign bitValid = togSync_r[1] ^ togSync_r[2];
    assign bitVal = sclBit_r;
    assign sclHigh = sclSync_r[1] & sclSync_r[2];
    assign sclFall = ~sclSync_r[1] & sclSync_r[2];
    assign startSeen = sclHigh & ~sdaSync_r[1] & sdaSync_r[2];
    assign stopSeen = sclHigh & sdaSync_r[1] & ~sdaSync_r[2];
    assign nvAllowed = wpSync_r[1]; // [R4] [R5]

    // Protocol state
    ctrl_state_t state_r;
    ctrl_state_t nextByteState;
    logic [3:0] bitCnt_r;
    logic [BYTE_W-1:0] rxShift_r;
    logic [BYTE_W-1:0] rxByte;
    logic [OP_W-1:0] op_r;
    logic [SLOT_W-1:0] slot_r;
    logic [POT_W-1:0] pot_r;
    logic byteAccept;
    logic accept;
    logic instrDone;
    logic dataDone;
    logic stepNow;
    logic [OP_W-1:0] newOp;
    logic [SLOT_W-1:0] newSlot;
    logic [POT_W-1:0] newPot;

    assign rxByte = {rxShift_r[BYTE_W-2:0], bitVal};
    assign newOp = rxByte[OP_MSB:OP_LSB];
    assign newSlot = rxByte[SLOT_MSB:SLOT_LSB];
    assign newPot = rxByte[POT_BIT];

    always_comb
    begin
        accept = 1'b0;
        nextByteState = ST_IDLE;
        case (state_r)
            ST_ADDR:
            begin
                if (rxByte == {TYPE_ID, selSync2_r}) // [R6]
                begin
                    accept = 1'b1;
                    nextByteState = ST_INSTR;
                end
            end
            ST_INSTR:
            begin
                accept = 1'b1;
                case (newOp)
                    OP_RD_WIPER, OP_RD_STORED:
                        nextByteState = ST_DATA_OUT; // [R9]
                    OP_WR_WIPER, OP_WR_STORED:
                        nextByteState = ST_DATA_IN; // [R9]
                    OP_RECALL, OP_STORE:
                        nextByteState = ST_IDLE; // [R10]
                    OP_INCDEC:
                        nextByteState = ST_INCDEC; // [R11]
                    default:
                        accept = 1'b0;
                endcase
            end
            ST_DATA_IN:
                accept = 1'b1; // [R14]
            ST_DATA_OUT:
                nextByteState = ST_DATA_OUT;
            default:
                nextByteState = ST_IDLE;
        endcase
    end

    assign byteAccept = bitValid && bitCnt_r == BIT_LAST && accept;
    assign instrDone = byteAccept && state_r == ST_INSTR;
    assign dataDone = byteAccept && state_r == ST_DATA_IN;
    assign stepNow = bitValid && state_r == ST_INCDEC && bitCnt_r != ACK_SLOT;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_r <= ST_BOOT_LO;
            bitCnt_r <= BIT_FIRST;
            rxShift_r <= 8'h00;
        end
        else if (state_r == ST_BOOT_LO)
            state_r <= ST_BOOT_HI; // [R3]
        else if (state_r == ST_BOOT_HI)
            state_r <= ST_IDLE; // [R3]
        else if (startSeen)
        begin
            state_r <= ST_ADDR;
            bitCnt_r <= BIT_FIRST;
        end
        else if (stopSeen)
            state_r <= ST_IDLE;
        else if (bitValid)
        begin
            if (state_r == ST_INCDEC)
                bitCnt_r <= BIT_FIRST;
            else if (bitCnt_r == ACK_SLOT)
            begin
                bitCnt_r <= BIT_FIRST;
                if (state_r == ST_DATA_OUT && bitVal)
                    state_r <= ST_IDLE;
            end
            else
            begin
                bitCnt_r <= 4'(bitCnt_r + 4'h1);
                rxShift_r <= rxByte;
                if (bitCnt_r == BIT_LAST && state_r != ST_DATA_OUT)
                    state_r <= nextByteState;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            op_r <= OP_RD_WIPER;
            slot_r <= 2'h0;
            pot_r <= POT_LO;
        end
        else if (instrDone)
        begin
            op_r <= newOp;
            slot_r <= newSlot;
            pot_r <= newPot;
        end
    end

    // Stored-setting memory requests
    logic wrEn_r;
    logic [ADDR_W-1:0] wrAddr_r;
    logic [WIPER_W-1:0] wrData_r;
    logic rdEn_r;
    logic [ADDR_W-1:0] rdAddr_r;
    logic loadTx_r;
    logic recall_r;
    logic [POT_W-1:0] recallPot_r;
    logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_r;
    logic recallGo_r;
    logic [POT_W-1:0] recallPotGo_r;
    logic loadGo_r;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wrEn_r <= 1'b0;
            wrAddr_r <= BOOT_ADDR_LO;
            wrData_r <= WIPER_MIN;
            rdEn_r <= 1'b0;
            rdAddr_r <= BOOT_ADDR_LO;
            loadTx_r <= 1'b0;
            recall_r <= 1'b0;
            recallPot_r <= POT_LO;
        end
        else
        begin
            wrEn_r <= 1'b0;
            rdEn_r <= 1'b0;
            loadTx_r <= 1'b0;
            recall_r <= 1'b0;
            if (state_r == ST_BOOT_LO || state_r == ST_BOOT_HI)
            begin
                rdEn_r <= 1'b1; // [R3]
                recall_r <= 1'b1; // [R3]
                rdAddr_r <= (state_r == ST_BOOT_LO) ? BOOT_ADDR_LO
                                                    : BOOT_ADDR_HI;
                recallPot_r <= (state_r == ST_BOOT_LO) ? POT_LO : POT_HI;
            end
            else if (instrDone)
            begin
                rdAddr_r <= {newPot, newSlot}; // [R2]
                recallPot_r <= newPot;
                wrAddr_r <= {newPot, newSlot};
                wrData_r <= wiper_r[newPot];
                if (newOp == OP_RD_STORED)
                begin
                    rdEn_r <= 1'b1; // [R9]
                    loadTx_r <= 1'b1;
                end
                if (newOp == OP_RECALL)
                begin
                    rdEn_r <= 1'b1; // [R10]
                    recall_r <= 1'b1;
                end
                // A refused store is still acknowledged
                if (newOp == OP_STORE && nvAllowed)
                    wrEn_r <= 1'b1; // [R10] [R4] [R14]
            end
            else if (dataDone && op_r == OP_WR_STORED)
            begin
                wrAddr_r <= {pot_r, slot_r};
                wrData_r <= rxByte[WIPER_W-1:0];
                wrEn_r <= nvAllowed; // [R4] [R5] [R14]
            end
        end
    end

    // Read data stand one cycle after the request, so use them then
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            recallGo_r <= 1'b0;
            recallPotGo_r <= POT_LO;
            loadGo_r <= 1'b0;
        end
        else
        begin
            recallGo_r <= recall_r; // [R3] [R10]
            recallPotGo_r <= recallPot_r;
            loadGo_r <= loadTx_r; // [R9]
        end
    end

    assign memBus.wrEn = wrEn_r;
    assign memBus.wrAddr = wrAddr_r;
    assign memBus.wrData = wrData_r;
    assign memBus.rdEn = rdEn_r;
    assign memBus.rdAddr = rdAddr_r;

    // Wiper position registers
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            wiper_r <= '0; // [R1]
        else
        begin
            if (recallGo_r)
                wiper_r[recallPotGo_r] <= memBus.rdData; // [R3] [R10]
            if (dataDone && op_r == OP_WR_WIPER)
                wiper_r[pot_r] <= rxByte[WIPER_W-1:0]; // [R1] [R9] [R4]
            // Steps saturate at the array ends rather than wrap
            if (stepNow && bitVal && wiper_r[pot_r] != WIPER_MAX)
                wiper_r[pot_r] <= 6'(wiper_r[pot_r] + 6'h01); // [R11]
            if (stepNow && !bitVal && wiper_r[pot_r] != WIPER_MIN)
                wiper_r[pot_r] <= 6'(wiper_r[pot_r] - 6'h01); // [R11]
        end
    end

    // One-hot tap switch per pot
    logic [NUM_POTS-1:0][TAP_COUNT-1:0] tapSel_r;
    for (genvar p = 0; p < NUM_POTS; p++)
    begin : g_tap
        always_ff @(posedge sys_clk)
        begin
            if (!reset_n)
                tapSel_r[p] <= TAP_ONE;
            else
                tapSel_r[p] <= TAP_ONE << wiper_r[p]; // [R7] [R8]
        end
    end

    // Read data byte
    logic [BYTE_W-1:0] txByte_r;
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            txByte_r <= 8'h00;
        else if (instrDone && newOp == OP_RD_WIPER)
            txByte_r <= 8'(wiper_r[newPot]); // [R9]
        else if (loadGo_r)
            txByte_r <= 8'(memBus.rdData); // [R9]
    end

    // Open-drain data drive, changed only after the clock has fallen
    logic ackReq_r;
    logic ackOn_r;
    logic sdaOe_r;
    logic sdaOut_r;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ackReq_r <= 1'b0;
            ackOn_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end
        else if (startSeen || stopSeen)
        begin
            ackReq_r <= 1'b0;
            ackOn_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end
        else
        begin
            if (byteAccept)
                ackReq_r <= 1'b1;
            if (sclFall)
            begin
                if (ackReq_r)
                begin
                    sdaOe_r <= 1'b1; // [R12]
                    ackOn_r <= 1'b1;
                    ackReq_r <= 1'b0;
                end
                else if (ackOn_r)
                begin
                    ackOn_r <= 1'b0;
                    sdaOe_r <= (state_r == ST_DATA_OUT) &&
                               !txByte_r[MSB_IDX]; // [R12]
                end
                else if (state_r == ST_DATA_OUT && bitCnt_r < ACK_SLOT)
                    sdaOe_r <= !txByte_r[3'(BIT_LAST - bitCnt_r)]; // [R12]
                else
                    sdaOe_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        sdaOut_r <= 1'b0; // [R12]
    end

    assign sdaOut = sdaOut_r;
    assign sdaOe = sdaOe_r;
    assign wiperPos = wiper_r;
    assign tapSelect = tapSel_r;
endmodule : dual_wiper_setting_store

//--- hdl/pot_pkg.sv
// Shared constants and types for the dual wiper setting store
package pot_pkg;
    localparam int NUM_POTS = 2;
    localparam int WIPER_W = 6;
    localparam int SLOTS = 4;
    localparam int SLOT_W = 2;
    localparam int POT_W = 1;
    localparam int ADDR_W = POT_W + SLOT_W;
    localparam int MEM_DEPTH = NUM_POTS * SLOTS;
    localparam int RES_ELEMENTS = 63;
    localparam int TAP_COUNT = RES_ELEMENTS + 1;
    localparam int SEL_W = 4;
    localparam int BYTE_W = 8;
    localparam int OP_W = 4;

    localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
    localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
    localparam logic [TAP_COUNT-1:0] TAP_ONE = 64'h0000_0000_0000_0001;

    // Arbitrary upper nibble of the slave address byte
    localparam logic [SEL_W-1:0] DEV_TYPE_ID = 4'h5;

    // Bit counter positions inside one nine-clock byte slot
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [2:0] MSB_IDX = 3'h7;

    // Instruction byte layout: opcode, slot, reserved, pot
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 4;
    localparam int SLOT_MSB = 3;
    localparam int SLOT_LSB = 2;
    localparam int POT_BIT = 0;

    localparam logic [OP_W-1:0] OP_RD_WIPER = 4'h9;
    localparam logic [OP_W-1:0] OP_WR_WIPER = 4'hA;
    localparam logic [OP_W-1:0] OP_RD_STORED = 4'hB;
    localparam logic [OP_W-1:0] OP_WR_STORED = 4'hC;
    localparam logic [OP_W-1:0] OP_RECALL = 4'hD;
    localparam logic [OP_W-1:0] OP_STORE = 4'hE;
    localparam logic [OP_W-1:0] OP_INCDEC = 4'h2;

    localparam logic [ADDR_W-1:0] BOOT_ADDR_LO = 3'h0;
    localparam logic [ADDR_W-1:0] BOOT_ADDR_HI = 3'h4;
    localparam logic [POT_W-1:0] POT_LO = 1'h0;
    localparam logic [POT_W-1:0] POT_HI = 1'h1;

    typedef enum logic [3:0] {
        ST_BOOT_LO,
        ST_BOOT_HI,
        ST_IDLE,
        ST_ADDR,
        ST_INSTR,
        ST_DATA_IN,
        ST_DATA_OUT,
        ST_INCDEC
    } ctrl_state_t;
endpackage : pot_pkg

//--- hdl/setting_mem_if.sv
// Carrier between the controller and the stored-setting memory
`timescale 1ns/100ps
interface setting_mem_if;
    import pot_pkg::*;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [WIPER_W-1:0] wrData;
    logic rdEn;
    logic [ADDR_W-1:0] rdAddr;
    logic [WIPER_W-1:0] rdData;
    modport ctrl (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
    modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface : setting_mem_if

//--- hdl/stored_setting_mem.sv
// Stored-setting array, four slots per potentiometer
`timescale 1ns/100ps
module stored_setting_mem
(
    input wire logic sys_clk,
    input wire logic reset_n,
    setting_mem_if.mem port
);
    import pot_pkg::*;
    logic [WIPER_W-1:0] slot_r [MEM_DEPTH];
    logic [WIPER_W-1:0] rdData_r;

    // Reset stands in for a fresh power-up, so contents clear to zero
    for (genvar e = 0; e < MEM_DEPTH; e++)
    begin : g_slot
        always_ff @(posedge sys_clk)
        begin
            if (!reset_n)
                slot_r[e] <= WIPER_MIN;
            else if (port.wrEn && port.wrAddr == ADDR_W'(e))
                slot_r[e] <= port.wrData;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rdData_r <= WIPER_MIN;
        else if (port.rdEn)
            rdData_r <= slot_r[port.rdAddr];
    end

    assign port.rdData = rdData_r;
endmodule : stored_setting_mem

//--- verif/dual_wiper_setting_store_monitor.sv
// Port checker for the dual wiper setting store
`timescale 1ns/100ps
module dual_wiper_setting_store_monitor
#(
    parameter logic [pot_pkg::SEL_W-1:0] TYPE_ID = pot_pkg::DEV_TYPE_ID
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [pot_pkg::SEL_W-1:0] deviceSelect,
    input wire logic writeProtectN,
    input wire logic [pot_pkg::NUM_POTS-1:0][pot_pkg::WIPER_W-1:0] wiperPos,
    input wire logic [pot_pkg::NUM_POTS-1:0][pot_pkg::TAP_COUNT-1:0] tapSelect
);
    import pot_pkg::*;
    logic [3:0] idleCnt_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Bus idle: both lines high, counted so a quiet stretch is recognised
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !(sclClk && sdaIn))
            idleCnt_r <= 4'h0;
        else if (idleCnt_r != 4'hF)
            idleCnt_r <= idleCnt_r + 4'h1;
    end

    sequence s_oe_held;
        sdaOe [*8];
    endsequence
    sequence s_wiper_zero;
        (wiperPos == '0) [*4];
    endsequence

    a_sda_drain_only : assert property (sdaOut == 1'b0)
        else $error("data output driven high");
    a_tap_follows_wiper : assert property (
        tapSelect[0] == (TAP_ONE << $past(wiperPos[0])) &&
        tapSelect[1] == (TAP_ONE << $past(wiperPos[1])))
        else $error("tap select does not follow wiper");
    a_tap_one_hot : assert property (
        $onehot(tapSelect[0]) && $onehot(tapSelect[1]))
        else $error("tap select not one-hot");
    a_oe_scl_low : assert property ($changed(sdaOe) |-> !sclClk)
        else $error("data line changed while serial clock high");
    a_ack_hold : assert property ($rose(sdaOe) |-> s_oe_held)
        else $error("data pull-down released too early");
    a_reset_clear : assert property (disable iff (1'b0)
        !reset_n |=> !sdaOe && wiperPos == '0 && tapSelect[0] == TAP_ONE)
        else $error("outputs not cleared by reset");
    a_boot_load : assert property ($rose(reset_n) |-> s_wiper_zero)
        else $error("wiper not loaded from cleared first setting");
    a_idle_wiper : assert property (idleCnt_r == 4'hF |-> $stable(wiperPos))
        else $error("wiper moved while bus idle");
endmodule : dual_wiper_setting_store_monitor

bind dual_wiper_setting_store dual_wiper_setting_store_monitor
    #(.TYPE_ID(TYPE_ID)) u_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
    .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .deviceSelect(deviceSelect), .writeProtectN(writeProtectN),
    .wiperPos(wiperPos), .tapSelect(tapSelect));

//--- verif/dual_wiper_setting_store_tb_top.sv
// Testbench top for the dual wiper setting store
`timescale 1ns/100ps
module dual_wiper_setting_store_tb_top;
    import pot_pkg::*;
    localparam logic [SEL_W-1:0] MY_SEL = 4'hA;
    logic sys_clk = 1'b0;
    logic linkClk = 1'b0;
    logic reset_n, sdaOut, sdaOe, writeProtectN, sclClk, sdaPullLow;
    logic [SEL_W-1:0] deviceSelect, addrSel;
    logic [NUM_POTS-1:0][WIPER_W-1:0] wiperPos;
    logic [NUM_POTS-1:0][TAP_COUNT-1:0] tapSelect;
    wire logic sdaLine = !(sdaPullLow || sdaOe);
    int fails = 0;
    int check_count = 0;

    always #20 sys_clk = ~sys_clk;
    initial
    begin
        #7;
        forever #15 linkClk = ~linkClk;
    end

    dual_wiper_setting_store u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .sclClk(sclClk), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .deviceSelect(deviceSelect), .writeProtectN(writeProtectN),
        .wiperPos(wiperPos), .tapSelect(tapSelect));
    two_wire_master_model u_master (.linkClk(linkClk), .sdaLine(sdaLine),
        .sclClk(sclClk), .sdaPullLow(sdaPullLow));

    task automatic check(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic write_op(input logic [3:0] op, input logic [1:0] slot,
        input logic pot, input logic [5:0] val, output logic ack);
        logic a1, a2, a3;
        a3 = 1'b1;
        u_master.start_cond();
        u_master.send_byte({DEV_TYPE_ID, addrSel}, a1);
        u_master.send_byte({op, slot, 1'b0, pot}, a2);
        if (op == OP_WR_WIPER || op == OP_WR_STORED)
            u_master.send_byte({2'b00, val}, a3);
        u_master.stop_cond();
        ack = a1 & a2 & a3;
    endtask : write_op

    task automatic read_op(input logic [3:0] op, input logic [1:0] slot,
        input logic pot, output logic [7:0] d);
        logic a;
        u_master.start_cond();
        u_master.send_byte({DEV_TYPE_ID, addrSel}, a);
        u_master.send_byte({op, slot, 1'b0, pot}, a);
        u_master.get_byte(d);
        u_master.stop_cond();
    endtask : read_op

    task automatic step_op(input logic pot, input logic up, input int n);
        logic a;
        u_master.start_cond();
        u_master.send_byte({DEV_TYPE_ID, addrSel}, a);
        u_master.send_byte({OP_INCDEC, 2'h0, 1'b0, pot}, a);
        repeat (n) u_master.put_bit(up, a);
        u_master.stop_cond();
    endtask : step_op

    task automatic t_boot;
        check("wiper0 at power-up", 64'h0, 64'(wiperPos[0]));
        check("wiper1 at power-up", 64'h0, 64'(wiperPos[1]));
        $display("test boot done");
    endtask : t_boot

    task automatic t_wiper;
        logic a;
        logic [7:0] d;
        write_op(OP_WR_WIPER, 2'h0, POT_LO, 6'h2A, a);
        check("wiper write ack", 64'h1, 64'(a));
        check("wiper0", 64'h2A, 64'(wiperPos[0]));
        check("wiper1 untouched", 64'h0, 64'(wiperPos[1]));
        check("tap0", TAP_ONE << 42, tapSelect[0]);
        write_op(OP_WR_WIPER, 2'h0, POT_HI, 6'h3F, a);
        check("tap1 top end", 64'h8000_0000_0000_0000, tapSelect[1]);
        read_op(OP_RD_WIPER, 2'h0, POT_LO, d);
        check("wiper0 read", 64'h2A, 64'(d));
        $display("test wiper done");
    endtask : t_wiper

    task automatic t_stored;
        logic a;
        logic [7:0] d;
        write_op(OP_WR_STORED, 2'h3, POT_HI, 6'h27, a);
        check("stored write ack", 64'h1, 64'(a));
        write_op(OP_RECALL, 2'h3, POT_HI, 6'h00, a);
        check("recalled wiper1", 64'h27, 64'(wiperPos[1]));
        write_op(OP_STORE, 2'h2, POT_LO, 6'h00, a);
        read_op(OP_RD_STORED, 2'h2, POT_LO, d);
        check("stored slot2 pot0", 64'h2A, 64'(d));
        read_op(OP_RD_STORED, 2'h3, POT_HI, d);
        check("stored slot3 pot1", 64'h27, 64'(d));
        $display("test stored done");
    endtask : t_stored

    task automatic t_protect;
        logic a;
        logic [7:0] d;
        @(posedge sys_clk);
        #1 writeProtectN = 1'b0;
        repeat (6) @(posedge sys_clk);
        write_op(OP_WR_STORED, 2'h2, POT_LO, 6'h05, a);
        check("blocked write ack", 64'h1, 64'(a));
        write_op(OP_WR_WIPER, 2'h0, POT_HI, 6'h0C, a);
        check("wiper1 under protect", 64'h0C, 64'(wiperPos[1]));
        write_op(OP_STORE, 2'h3, POT_HI, 6'h00, a);
        read_op(OP_RD_STORED, 2'h2, POT_LO, d);
        check("protected slot2 pot0", 64'h2A, 64'(d));
        read_op(OP_RD_STORED, 2'h3, POT_HI, d);
        check("protected slot3 pot1", 64'h27, 64'(d));
        @(posedge sys_clk) #1 writeProtectN = 1'b1;
        $display("test protect done");
    endtask : t_protect

    task automatic t_address;
        logic a;
        for (int b = 0; b < SEL_W; b++)
        begin
            addrSel = MY_SEL ^ (4'h1 << b);
            write_op(OP_WR_WIPER, 2'h0, POT_LO, 6'h01, a);
            check("foreign address ack", 64'h0, 64'(a));
            check("wiper0 kept", 64'h2A, 64'(wiperPos[0]));
        end
        @(posedge sys_clk) #1 deviceSelect = ~MY_SEL;
        addrSel = ~MY_SEL;
        write_op(OP_WR_WIPER, 2'h0, POT_LO, 6'h15, a);
        check("other select ack", 64'h1, 64'(a));
        check("wiper0 other select", 64'h15, 64'(wiperPos[0]));
        @(posedge sys_clk) #1 deviceSelect = MY_SEL;
        addrSel = MY_SEL;
        $display("test address done");
    endtask : t_address

    // Stop adds one down step, so expected values allow for it
    task automatic t_incdec;
        logic a;
        write_op(OP_WR_WIPER, 2'h0, POT_LO, 6'h3D, a);
        step_op(POT_LO, 1'b1, 4);
        check("stepped up, saturated", 64'h3E, 64'(wiperPos[0]));
        write_op(OP_WR_WIPER, 2'h0, POT_HI, 6'h02, a);
        step_op(POT_HI, 1'b0, 4);
        check("stepped down, saturated", 64'h0, 64'(wiperPos[1]));
        $display("test incdec done");
    endtask : t_incdec

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        reset_n = 1'b0;
        deviceSelect = MY_SEL;
        addrSel = MY_SEL;
        writeProtectN = 1'b1;
        fork
            u_master.reset_clocks();
            repeat (12) @(posedge sys_clk);
        join
        #1 reset_n = 1'b1;
        // Link-side reset lifts only on serial clock edges
        u_master.reset_clocks();
        repeat (10) @(posedge sys_clk);
        t_boot();
        t_wiper();
        t_stored();
        t_protect();
        t_address();
        t_incdec();
        end_sim();
    end

    // Some 22 frames of about 500 cycles each, with ample margin
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : dual_wiper_setting_store_tb_top

//--- verif/two_wire_master_model.sv
// Two-wire bus master driving serial clock and open-drain data
`timescale 1ns/100ps
module two_wire_master_model
(
    input wire logic linkClk,
    input wire logic sdaLine,
    output logic sclClk,
    output logic sdaPullLow
);
    initial
    begin
        sclClk = 1'b1;
        sdaPullLow = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge linkClk);
        #1;
    endtask : ticks

    // Clock pulses with data released, so no frame edge is seen
    task automatic reset_clocks;
        repeat (3)
        begin
            ticks(2);
            sclClk = 1'b0;
            ticks(2);
            sclClk = 1'b1;
        end
    endtask : reset_clocks

    // Master alone makes the clock, 360 ns per phase to meet 320 ns minimum
    task automatic put_bit(input logic b, output logic seen);
        ticks(6);
        sdaPullLow = !b;
        ticks(6);
        sclClk = 1'b1;
        ticks(6);
        seen = sdaLine;
        ticks(6);
        sclClk = 1'b0;
    endtask : put_bit

    task automatic start_cond;
        sdaPullLow = 1'b1;
        ticks(12);
        sclClk = 1'b0;
    endtask : start_cond

    // Clock rises with data low first, which an inc/dec frame counts
    task automatic stop_cond;
        ticks(6);
        sdaPullLow = 1'b1;
        ticks(6);
        sclClk = 1'b1;
        ticks(12);
        sdaPullLow = 1'b0;
        ticks(12);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask : send_byte

    task automatic get_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, d[i]);
        put_bit(1'b1, s);
    endtask : get_byte
endmodule : two_wire_master_model
